// file: adcr_pkg.sv
// adcr_pkg: constants shared by the converter control registers
// assumes an 8-bit special-function-register bus and one 100 MHz clock
package adcr_pkg;
   localparam logic [7:0] ADDR_CONFIG  = 8'hbc;  // converter_config offset
   localparam logic [7:0] ADDR_RESULT  = 8'hbe;  // conversion_result offset
   localparam logic [7:0] ADDR_CONTROL = 8'he8;  // converter_control offset
   localparam logic [7:0] RST_CONFIG   = 8'hf8;  // config after reset
   localparam logic [7:0] RST_RESULT   = 8'h00;  // result after reset
   localparam logic [7:0] RST_CONTROL  = 8'h00;  // control after reset
   localparam int DIV_LSB   = 3;                 // divider field bits 7..3
   localparam int GAIN_LSB  = 0;                 // gain field bits 1..0
   localparam int EN_BIT    = 7;                 // enable bit
   localparam int TM_BIT    = 6;                 // track mode bit
   localparam int DONE_BIT  = 5;                 // done flag bit
   localparam int BUSY_BIT  = 4;                 // busy bit
   localparam int WIN_BIT   = 3;                 // window flag bit
   localparam int SRC_LSB   = 0;                 // start source bits 2..0
   localparam int SAR_STEPS = 11;                // step clocks per conversion
   typedef enum logic [1:0] {
      ADCR_IDLE  = 2'b00,
      ADCR_CONV  = 2'b01,
      ADCR_DONE  = 2'b11
   } adcr_state_t;
   typedef enum logic [1:0] {
      ADCR_GAIN_HALF = 2'b00,
      ADCR_GAIN_ONE  = 2'b01,
      ADCR_GAIN_TWO  = 2'b10,
      ADCR_GAIN_FOUR = 2'b11
   } adcr_gain_t;
endpackage

// file: adcr_step_div.sv
// adcr_step_div: divides the core clock into the sar step clock pulse
// assumes the divider value is stable enough; a change does not restart the count, it applies at the next compare
module adcr_step_div #(
   parameter int DIV_W = 5
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             run,
   input  wire logic [DIV_W-1:0] divider,
   output logic                  step_tick
);
   // elaboration check: a zero-width counter cannot count
   if (DIV_W < 1) begin : g_bad_div_w
      $error("divider width must be at least one");
   end

   typedef struct packed {
      logic [DIV_W-1:0] cnt;   // core clocks since last step
      logic             tick;  // one-cycle step pulse
   } adcr_div_t;

   adcr_div_t st_ff;
   adcr_div_t nxt_st;

   // period is divider+1 core clocks, so divider = fcore/fstep - 1
   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (!run) begin
         nxt_st.cnt = '0;                      // cleared to zero while idle
      end else if (st_ff.cnt >= divider) begin
         nxt_st.cnt  = '0;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.cnt = st_ff.cnt + 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign step_tick = st_ff.tick;
endmodule

// file: adcr_top.sv
// adcr_top: control, config and result registers of an 8-bit sar converter
// assumes a one-cycle sfr write/read strobe and an analog core that
// delivers its code on sar_result when the step sequence ends
// register map, every register eight bits wide:
//    converter_config   divider in 7..3, bit 2 reads zero, gain in 1..0
//    conversion_result  last code, software may overwrite it
//    converter_control  enable, track mode, done, busy, window, source
//
// the start source and window flag are plain storage here; the logic
// that decodes them sits outside this block
//
// a start moves the sequencer to converting; after STEPS step ticks it
// spends one done cycle sampling the code, then goes back to idle
//
// a write lands at its strobe edge, a read answers one cycle later and
// the read data return to zero the cycle after that
module adcr_top #(
   parameter int DATA_W = 8,
   parameter int STEPS  = adcr_pkg::SAR_STEPS
) (
   input  wire logic              clk,
   input  wire logic              reset_n,
   // special-function-register bus
   input  wire logic [7:0]        sfr_addr,
   input  wire logic              sfr_wr,
   input  wire logic              sfr_rd,
   input  wire logic [7:0]        sfr_wdata,
   output logic [7:0]             sfr_rdata,
   // start request and code from the analog core
   input  wire logic              conv_start,
   input  wire logic [DATA_W-1:0] sar_result,
   // controls and status towards the analog core
   output logic                   converter_enable,
   output logic                   track_enable,
   output logic [1:0]             amplifier_gain_select,
   output logic                   sar_step_clock,
   output logic                   conversion_busy,
   output logic                   conversion_done_flag
);
   // elaboration checks: the result register is fixed at eight bits and
   // the step counter below is eight bits wide, so larger step counts
   // would silently wrap
   if (DATA_W != 8) begin : g_bad_data_w
      $error("result width must be eight bits");
   end
   if (STEPS < 1 || STEPS > 255) begin : g_bad_steps
      $error("step count out of range");
   end

   ////////////////////////////////////////////////////////////////////
   // state

   // all state but the divider's counter in one packed struct, so reset and the register stage
   // each touch it in one place
   typedef struct packed {
      logic [7:0]          config_r;   // converter_config
      logic [7:0]          result_r;   // conversion_result
      logic                en;         // converter enable
      logic                tm;         // track mode select
      logic                done;       // sticky done flag
      logic                win;        // window flag, software held
      logic [2:0]          src;        // start source select
      adcr_pkg::adcr_state_t fsm;      // conversion sequencer
      logic [7:0]          steps;      // step clocks remaining
      logic [7:0]          rdata;      // registered read data
      logic                step_clk;   // visible step clock level
      logic                track;      // track switch closed
      logic                busy;       // conversion running, registered
   } adcr_st_t;

   // registered state, its next value and the divider's pulse
   adcr_st_t st_ff;
   adcr_st_t nxt_st;
   logic     step_tick;                // one-cycle pulse per step

   // field decode used by all three register writes and the busy-write start
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // control register as software reads it; busy is the live sequencer
   // state, so a write of zero to that bit has nothing to land in
   function automatic logic [7:0] ctrl_word(input adcr_st_t s);
      return {s.en, s.tm, s.done, s.busy, s.win, s.src};
   endfunction

   ////////////////////////////////////////////////////////////////////
   // step clock divider

   // runs only while converting, so every conversion starts with a
   // full step period rather than a leftover fraction of one
   adcr_step_div #(
      .DIV_W (5)
   ) u_div (
      .clk       (clk),
      .reset_n   (reset_n),
      .run       (st_ff.fsm == adcr_pkg::ADCR_CONV),
      .divider   (st_ff.config_r[adcr_pkg::DIV_LSB +: 5]),
      .step_tick (step_tick)
   );

   ////////////////////////////////////////////////////////////////////
   // next state

   // one process works out the whole next state; the register stage
   // below only copies it
   always_comb begin
      nxt_st = st_ff;
      // software writes come first so that the sequencer below may
      // override them; that is how a hardware done set beats a clear
      // config takes the whole byte except bit 2, which has no storage
      if (sfr_wr && hit(sfr_addr, adcr_pkg::ADDR_CONFIG)) begin
         nxt_st.config_r = sfr_wdata;
         nxt_st.config_r[2] = 1'b0;                // unused bit
      end
      if (sfr_wr && hit(sfr_addr, adcr_pkg::ADDR_RESULT)) begin
         nxt_st.result_r = sfr_wdata;
      end
      // control write sets or clears done and window directly; busy is
      // read-only here and only a one there can start the sequencer
      if (sfr_wr && hit(sfr_addr, adcr_pkg::ADDR_CONTROL)) begin
         nxt_st.en   = sfr_wdata[adcr_pkg::EN_BIT];
         nxt_st.tm   = sfr_wdata[adcr_pkg::TM_BIT];
         nxt_st.done = sfr_wdata[adcr_pkg::DONE_BIT];
         nxt_st.win  = sfr_wdata[adcr_pkg::WIN_BIT];
         nxt_st.src  = sfr_wdata[adcr_pkg::SRC_LSB +: 3];
      end
      // sequencer; writing one to busy also starts a conversion
      case (st_ff.fsm)
         adcr_pkg::ADCR_IDLE: begin
            // a start needs the enable already set; a write that sets
            // enable and busy together only enables
            if (st_ff.en && (conv_start ||
                (sfr_wr && hit(sfr_addr, adcr_pkg::ADDR_CONTROL) &&
                 sfr_wdata[adcr_pkg::BUSY_BIT]))) begin
               nxt_st.fsm   = adcr_pkg::ADCR_CONV;
               nxt_st.steps = 8'(STEPS);
            end
         end
         adcr_pkg::ADCR_CONV: begin
            if (!st_ff.en) begin
               // abort on disable: no done, step clock parked low so the
               // analog core never sees a half step while idle
               nxt_st.fsm      = adcr_pkg::ADCR_IDLE;
               nxt_st.step_clk = 1'b0;
            end else if (step_tick) begin
               // one edge of the visible step clock per divider period
               nxt_st.step_clk = ~st_ff.step_clk;
               if (st_ff.steps == 8'h01) begin
                  nxt_st.fsm = adcr_pkg::ADCR_DONE;
               end else begin
                  nxt_st.steps = st_ff.steps - 8'h01;
               end
            end
         end
         adcr_pkg::ADCR_DONE: begin
            // busy falls here; set wins over a same-cycle clear
            // the analog core still drives its code in this cycle
            nxt_st.result_r = sar_result;
            nxt_st.done     = 1'b1;
            nxt_st.fsm      = adcr_pkg::ADCR_IDLE;
            nxt_st.step_clk = 1'b0;
         end
         default: begin
            nxt_st.fsm = adcr_pkg::ADCR_IDLE;
         end
      endcase
      // normal mode tracks whenever enabled and idle; low-power mode
      // tracks only just before a conversion, left to the start source
      nxt_st.track = nxt_st.en && (nxt_st.fsm == adcr_pkg::ADCR_IDLE) &&
                     !nxt_st.tm;
      // busy kept as a flop of its own so the output needs no decode;
      // it stays high through the done cycle and falls with the done set
      nxt_st.busy = nxt_st.fsm != adcr_pkg::ADCR_IDLE;
      // registered read mux; unmapped reads return zero
      // zero between reads keeps the bus quiet when nothing is asked
      nxt_st.rdata = 8'h00;
      if (sfr_rd) begin
         case (sfr_addr)
            adcr_pkg::ADDR_CONFIG:  nxt_st.rdata = st_ff.config_r;
            adcr_pkg::ADDR_RESULT:  nxt_st.rdata = st_ff.result_r;
            adcr_pkg::ADDR_CONTROL: nxt_st.rdata = ctrl_word(st_ff);
            default:                nxt_st.rdata = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register

   // reset loads constants only; the struct clear gives every field not
   // named below its zero value
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff          <= '0;
         st_ff.config_r <= adcr_pkg::RST_CONFIG;
         st_ff.result_r <= adcr_pkg::RST_RESULT;
         st_ff.fsm      <= adcr_pkg::ADCR_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs, all from flip-flops
   // gain is a straight slice of the config flops, no decode

   assign sfr_rdata             = st_ff.rdata;
   assign converter_enable      = st_ff.en;
   assign track_enable          = st_ff.track;
   assign amplifier_gain_select = st_ff.config_r[adcr_pkg::GAIN_LSB +: 2];
   assign sar_step_clock        = st_ff.step_clk;
   assign conversion_busy       = st_ff.busy;
   assign conversion_done_flag  = st_ff.done;
endmodule

// file: adcr_assertions.sv
// adcr_assertions: port checks on adcr_top
// assumes one clock domain and an async active-low reset
module adcr_chk #(
   parameter int DATA_W = 8,
   parameter int STEPS  = 11
) (
   input wire logic              clk,
   input wire logic              reset_n,
   input wire logic              sfr_wr,
   input wire logic              sfr_rd,
   input wire logic              conv_start,
   input wire logic [7:0]        sfr_addr,
   input wire logic [7:0]        sfr_wdata,
   input wire logic [7:0]        sfr_rdata,
   input wire logic [DATA_W-1:0] sar_result,
   input wire logic              converter_enable,
   input wire logic              track_enable,
   input wire logic              sar_step_clock,
   input wire logic              conversion_busy,
   input wire logic              conversion_done_flag,
   input wire logic [1:0]        amplifier_gain_select
);
   wire logic [1:0] wr_gain = sfr_wdata[1:0]; // gain field of the write
   wire logic       wr_en   = sfr_wdata[7];   // enable bit of the write
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_start_sets_busy: assert property (conv_start && converter_enable && !conversion_busy
      && !sfr_wr |=> conversion_busy) else $error("start not taken");
   a_disabled_idle: assert property (!converter_enable && !conversion_busy && !sfr_wr
      |=> !conversion_busy) else $error("conversion while disabled");
   a_enable_write: assert property (sfr_wr && sfr_addr == 8'he8
      |=> converter_enable == $past(wr_en)) else $error("enable write lost");
   a_gain_write: assert property (sfr_wr && sfr_addr == 8'hbc
      |=> amplifier_gain_select == $past(wr_gain)) else $error("gain write lost");
   a_busy_no_track: assert property (conversion_busy |-> !track_enable)
      else $error("tracking during conversion");
   a_idle_step_low: assert property (!conversion_busy |-> !sar_step_clock)
      else $error("step clock runs while idle");
   a_fall_sets_done: assert property ($fell(conversion_busy) && converter_enable
      |-> conversion_done_flag) else $error("done not set on busy fall");
   a_done_sticky: assert property (conversion_done_flag && !(sfr_wr && sfr_addr == 8'he8)
      |=> conversion_done_flag) else $error("done dropped by itself");
   a_rdata_quiet: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
      else $error("read data without read");
   a_cfg_bit2_zero: assert property (sfr_rd && sfr_addr == 8'hbc
      |=> !sfr_rdata[2]) else $error("config bit two reads one");
endmodule
bind adcr_top adcr_chk #(.DATA_W(DATA_W), .STEPS(STEPS)) u_chk (.clk(clk), .reset_n(reset_n),
   .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .conv_start(conv_start), .sfr_addr(sfr_addr),
   .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sar_result(sar_result),
   .converter_enable(converter_enable), .track_enable(track_enable),
   .sar_step_clock(sar_step_clock), .conversion_busy(conversion_busy),
   .conversion_done_flag(conversion_done_flag), .amplifier_gain_select(amplifier_gain_select));

// file: adcr_sar_model.sv
// adcr_sar_model: stands in for the analog sar core
// assumes its code is only valid while conversion_busy is high
module adcr_sar_model #(
   parameter int DATA_W = 8
) (
   input  wire logic              clk,
   input  wire logic              busy,
   input  wire logic [DATA_W-1:0] code,
   output logic [DATA_W-1:0]      sar_result
);
   logic [DATA_W-1:0] junk_ff = '0; // changes every cycle, seen only outside a conversion
   always_ff @(posedge clk) begin
      junk_ff <= junk_ff + 8'h35;
   end
   // a late sample sees garbage, not a stale code
   assign sar_result = busy ? code : junk_ff;
endmodule

// file: adc_control_registers_tb.sv
// adc_control_registers_tb: self-checking bench for adcr_top
// assumes adcr_sar_model beside it; inputs move on falling edges
module adc_control_registers_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk, reset_n, sfr_wr, sfr_rd, conv_start, prev;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, sar_result, code, rd_v;
   logic       converter_enable, track_enable, sar_step_clock, conversion_busy, done;
   logic [1:0] gain;
   int         err_total, num_checks, n, t0, per;
   typedef struct {logic w; logic [7:0] a, d, e;} adcr_row_t;
   adcr_row_t rows[10] = '{'{0, 8'hbc, 8'h00, 8'hf8}, '{0, 8'hbe, 8'h00, 8'h00},
      '{0, 8'he8, 8'h00, 8'h00}, '{1, 8'hbc, 8'h08, 8'h08}, '{1, 8'hbc, 8'h31, 8'h31},
      '{1, 8'hbc, 8'hfe, 8'hfa}, '{1, 8'hbc, 8'h07, 8'h03}, '{1, 8'hbe, 8'h5a, 8'h5a},
      '{1, 8'he8, 8'h40, 8'h40}, '{1, 8'h10, 8'hff, 8'h00}};
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   adcr_top #(.DATA_W(8), .STEPS(2)) DUT (.clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .conv_start(conv_start), .sar_result(sar_result), .converter_enable(converter_enable),
      .track_enable(track_enable), .amplifier_gain_select(gain),
      .sar_step_clock(sar_step_clock), .conversion_busy(conversion_busy),
      .conversion_done_flag(done));
   adcr_sar_model #(.DATA_W(8)) u_sar (.clk(clk), .busy(conversion_busy), .code(code),
      .sar_result(sar_result));
   task chk(string nm, logic [7:0] e, logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("FAIL %s exp %h got %h", nm, e, g);
      end
   endtask
   task wr(logic [7:0] a, logic [7:0] d);
      @(negedge clk);
      {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask
   task rd(logic [7:0] a);
      @(negedge clk);
      {sfr_rd, sfr_addr} = {1'b1, a};
      @(negedge clk);
      sfr_rd = 1'b0;
      rd_v = sfr_rdata;
   endtask
   task final_report;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // watchdog: the whole run needs well under 1000 cycles
   initial begin
      #20000;
      err_total++;
      final_report;
   end
   initial begin
      {reset_n, sfr_wr, sfr_rd, conv_start, sfr_addr, sfr_wdata, code} = {4'h0, 24'h0_00a5};
      repeat (16) @(negedge clk);
      reset_n = 1;
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         if (rows[i].w && rows[i].a == 8'hbc) chk("gain", {6'h0, rows[i].d[1:0]}, {6'h0, gain});
         rd(rows[i].a);
         chk("reg", rows[i].e, rd_v);
      end
      wr(8'hbc, 8'h11);
      wr(8'he8, 8'h80);
      chk("track", 8'h01, {7'h0, track_enable});
      chk("enable", 8'h01, {7'h0, converter_enable});
      @(negedge clk) conv_start = 1;
      @(negedge clk) conv_start = 0;
      n    = 0;
      per  = 0;
      t0   = 0;
      prev = 1'b0;
      // step spacing must be divider plus one core clocks
      for (int c = 0; c < 200 && conversion_busy; c++) begin
         @(negedge clk);
         if (sar_step_clock !== prev) begin
            per = c - t0;
            t0 = c;
            n++;
         end
         prev = sar_step_clock;
      end
      chk("period", 8'h03, 8'(per));
      chk("toggles", 8'h02, 8'(n));
      chk("done", 8'h01, {7'h0, done});
      rd(8'hbe);
      chk("result", 8'ha5, rd_v);
      rd(8'he8);
      chk("control", 8'ha0, rd_v);
      code = 8'h3c;
      wr(8'he8, 8'h90);
      wr(8'he8, 8'h80);
      chk("busy", 8'h01, {7'h0, conversion_busy});
      for (int c = 0; c < 200 && conversion_busy; c++) @(negedge clk);
      rd(8'hbe);
      chk("result2", 8'h3c, rd_v);
      wr(8'he8, 8'h00);
      @(negedge clk) conv_start = 1;
      @(negedge clk) conv_start = 0;
      chk("idle", 8'h00, {7'h0, conversion_busy});
      wr(8'he8, 8'hc0);
      chk("lp_track", 8'h00, {7'h0, track_enable});
      // abort: disable mid-conversion while the step clock is high
      @(negedge clk) conv_start = 1'b1;
      @(negedge clk) conv_start = 1'b0;
      repeat (4) @(negedge clk);
      wr(8'he8, 8'h00);
      @(negedge clk);
      chk("abort_busy", 8'h00, {7'h0, conversion_busy});
      chk("abort_step", 8'h00, {7'h0, sar_step_clock});
      chk("abort_done", 8'h00, {7'h0, done});
      wr(8'he8, 8'ha0);
      reset_n = 1'b0;
      @(negedge clk) reset_n = 1'b1;
      rd(8'hbc);
      chk("cfg_rst", 8'hf8, rd_v);
      chk("en_rst", 8'h00, {7'h0, converter_enable});
      chk("done_rst", 8'h00, {7'h0, done});
      final_report;
   end
endmodule
